// [rtl/sbc_cfg_top.sv]
`timescale 1ns/1ps
`include "sbc_cfg_params.svh"

module sbc_cfg_top
  import sbc_cfg_pkg::*;
#(
  parameter logic [31:0] STEP_CYCLES = 32'(`SBC_STEP_CYCLES),
  parameter int          DUTY_W      = 10
)(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sclk,
  input  wire logic       spi_mosi,
  output logic            spi_miso_o,
  output logic            spi_miso_oe,
  input  wire logic       second_pwm,
  input  wire logic       first_on_timer,
  input  wire logic       second_on_timer,
  input  wire logic       external_switch_pin_control,
  output logic [1:0]      transceiver_mode,
  output logic            dominant_timeout_disable,
  output logic            high_side_switch,
  output logic            fail_safe_output_enable,
  output logic            first_pwm,
  output logic            inactivity_timer_running,
  output logic            sleep_request
);

  // pin synchronisers: cs_n, sclk, mosi, external control
  localparam int NPIN = 4;
  logic [NPIN-1:0] pin_in;
  logic [2:0]      sync_reg [NPIN];
  logic [NPIN-1:0] filt_reg;
  logic [NPIN-1:0] filt_d_reg;

  assign pin_in = {external_switch_pin_control, spi_mosi, spi_sclk, spi_cs_n};

  // three stages; a level counts once stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
        sync_reg[i]   <= (i == 0) ? 3'h7 : 3'h0;
        filt_reg[i]   <= (i == 0);
        filt_d_reg[i] <= (i == 0);
      end else begin
        sync_reg[i] <= {sync_reg[i][1:0], pin_in[i]};
        if (sync_reg[i][1] == sync_reg[i][2]) begin
          filt_reg[i] <= sync_reg[i][2];
        end
        filt_d_reg[i] <= filt_reg[i];
      end
    end
  end

  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic mosi_bit;
  logic ext_ctrl;

  assign cs_act    = ~filt_reg[0];
  assign sclk_rise = filt_reg[1] & ~filt_d_reg[1];
  assign sclk_fall = ~filt_reg[1] & filt_d_reg[1];
  assign mosi_bit  = filt_reg[2];
  assign ext_ctrl  = filt_reg[3];

  // register fields
  logic          inact_dis_reg;
  logic [3:0]    inact_sel_reg;
  sbc_lin_mode_e mode_reg;
  logic          dto_dis_reg;
  logic          sw_en_reg;
  sbc_sw_src_e   sw_src_reg;
  logic [3:0]    sw_spare_reg;
  logic          freq_reg;
  logic [1:0]    duty_up_reg;
  sbc_byte_t     duty_lo_reg;

  // spi frame engine state
  sbc_spi_state_e spi_state_reg;
  logic [4:0]     bit_cnt_reg;
  sbc_byte_t      hdr_reg;
  sbc_byte_t      dat_reg;
  sbc_byte_t      tx_reg;
  logic           miso_reg;
  logic           miso_oe_reg;
  logic           wr_pulse_reg;
  logic [6:0]     wr_addr_reg;
  sbc_byte_t      wr_data_reg;
  logic           access_pulse_reg;
  sbc_byte_t      hdr_next;
  sbc_byte_t      rd_data;

  // address decode shared by read mux and write path
  function automatic logic hit(input logic [6:0] a, input logic [6:0] want);
    hit = (a == want);
  endfunction : hit

  // timeout code to half-minute count
  function automatic logic [4:0] half_minutes(input logic [3:0] sel);
    unique case (sel)
      4'h0: half_minutes = 5'd4;
      4'h1: half_minutes = 5'd5;
      4'h2: half_minutes = 5'd6;
      4'h3: half_minutes = 5'd7;
      4'h4: half_minutes = 5'd8;
      4'h5: half_minutes = 5'd9;
      4'h6: half_minutes = 5'd10;
      4'h7: half_minutes = 5'd11;
      4'h8: half_minutes = 5'd12;
      4'h9: half_minutes = 5'd13;
      4'ha: half_minutes = 5'd16;
      4'hb: half_minutes = 5'd17;
      4'hc: half_minutes = 5'd20;
      4'hd: half_minutes = 5'd1;
      4'he: half_minutes = 5'd2;  // undefined code treated as one minute
      4'hf: half_minutes = 5'd2;
    endcase
  endfunction : half_minutes

  assign hdr_next = {hdr_reg[6:0], mosi_bit};

  // read mux; reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    if (hit(hdr_next[6:0], `SBC_ADDR_INACT)) begin
      rd_data[`SBC_INACT_DIS_BIT] = inact_dis_reg;
      rd_data[`SBC_INACT_SEL_HI:`SBC_INACT_SEL_LO] = inact_sel_reg;
    end else if (hit(hdr_next[6:0], `SBC_ADDR_XCVR)) begin
      rd_data[`SBC_MODE_HI:`SBC_MODE_LO] = mode_reg;
      rd_data[`SBC_DTO_DIS_BIT] = dto_dis_reg;
    end else if (hit(hdr_next[6:0], `SBC_ADDR_SWITCH)) begin
      rd_data[`SBC_SW_EN_BIT] = sw_en_reg;
      rd_data[`SBC_SW_SRC_HI:`SBC_SW_SRC_LO] = sw_src_reg;
      rd_data[`SBC_SW_SPARE_HI:0] = sw_spare_reg;
    end else if (hit(hdr_next[6:0], `SBC_ADDR_PWM_FREQ)) begin
      rd_data[`SBC_FREQ_BIT] = freq_reg;
    end else if (hit(hdr_next[6:0], `SBC_ADDR_DUTY_UPPER)) begin
      rd_data[`SBC_DUTY_UP_HI:0] = duty_up_reg;
    end else if (hit(hdr_next[6:0], `SBC_ADDR_DUTY_LOWER)) begin
      rd_data = duty_lo_reg;
    end
  end

  // spi frame engine: header byte, then data byte, mode 0
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      spi_state_reg    <= SBC_SPI_IDLE;
      bit_cnt_reg      <= 5'h0;
      hdr_reg          <= 8'h00;
      dat_reg          <= 8'h00;
      tx_reg           <= 8'h00;
      wr_pulse_reg     <= 1'b0;
      wr_addr_reg      <= 7'h00;
      wr_data_reg      <= 8'h00;
      access_pulse_reg <= 1'b0;
    end else begin
      wr_pulse_reg     <= 1'b0;
      access_pulse_reg <= 1'b0;
      if (!cs_act) begin
        spi_state_reg <= SBC_SPI_IDLE;  // a short frame is dropped
        bit_cnt_reg   <= 5'h0;
      end else begin
        unique case (spi_state_reg)
          SBC_SPI_IDLE: begin
            spi_state_reg <= SBC_SPI_HDR;
            bit_cnt_reg   <= 5'h0;
          end
          SBC_SPI_HDR: if (sclk_rise) begin
            hdr_reg     <= hdr_next;
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
            if (bit_cnt_reg == 5'(`SBC_HDR_BITS - 1)) begin
              tx_reg        <= rd_data;
              spi_state_reg <= SBC_SPI_DATA;
            end
          end
          SBC_SPI_DATA: if (sclk_rise) begin
            dat_reg     <= {dat_reg[6:0], mosi_bit};
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
            if (bit_cnt_reg == 5'(`SBC_FRAME_BITS - 1)) begin
              wr_pulse_reg     <= hdr_reg[7];
              wr_addr_reg      <= hdr_reg[6:0];
              wr_data_reg      <= {dat_reg[6:0], mosi_bit};
              access_pulse_reg <= 1'b1;
              spi_state_reg    <= SBC_SPI_HOLD;
            end
          end else if (sclk_fall) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
          SBC_SPI_HOLD: ;  // extra clocks ignored until cs_n rises
          default: spi_state_reg <= SBC_SPI_IDLE;
        endcase
      end
    end
  end

  // miso: read bits shifted on falling sclk, driven only while selected
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_oe_reg <= cs_act;
      if (!cs_act || spi_state_reg != SBC_SPI_DATA) begin
        miso_reg <= 1'b0;
      end else if (sclk_fall) begin
        miso_reg <= tx_reg[7];
      end
    end
  end

  // inactivity timer
  logic [31:0] step_cnt_reg;
  logic [4:0]  half_cnt_reg;
  logic        timer_run;
  logic        expire;

  assign timer_run = ~inact_dis_reg & (mode_reg != SBC_MODE_SLEEP);
  assign expire    = timer_run && (step_cnt_reg == STEP_CYCLES - 32'h1)
                     && (half_cnt_reg + 5'h1 >= half_minutes(inact_sel_reg));

  // half-minute steps, restarted by any completed spi access
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      step_cnt_reg <= 32'h0;
      half_cnt_reg <= 5'h0;
    end else if (!timer_run || access_pulse_reg || expire) begin
      step_cnt_reg <= 32'h0;
      half_cnt_reg <= 5'h0;
    end else if (step_cnt_reg == STEP_CYCLES - 32'h1) begin
      step_cnt_reg <= 32'h0;
      half_cnt_reg <= half_cnt_reg + 5'h1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 32'h1;
    end
  end

  // register writes; timer expiry forces sleep and wins over a write
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      inact_dis_reg <= 1'(`SBC_RST_INACT >> `SBC_INACT_DIS_BIT);
      inact_sel_reg <= 4'(`SBC_RST_INACT >> `SBC_INACT_SEL_LO);
      mode_reg      <= sbc_lin_mode_e'(2'(`SBC_RST_XCVR >> `SBC_MODE_LO));
      dto_dis_reg   <= 1'b0;
      sw_en_reg     <= 1'(`SBC_RST_SWITCH >> `SBC_SW_EN_BIT);
      sw_src_reg    <= sbc_sw_src_e'(3'(`SBC_RST_SWITCH >> `SBC_SW_SRC_LO));
      sw_spare_reg  <= 4'(`SBC_RST_SWITCH);
      freq_reg      <= 1'(`SBC_RST_PWM_FREQ >> `SBC_FREQ_BIT);
      duty_up_reg   <= 2'(`SBC_RST_DUTY_UPPER);
      duty_lo_reg   <= `SBC_RST_DUTY_LOWER;
    end else begin
      if (wr_pulse_reg) begin
        if (hit(wr_addr_reg, `SBC_ADDR_INACT)) begin
          inact_dis_reg <= wr_data_reg[`SBC_INACT_DIS_BIT];
          inact_sel_reg <= wr_data_reg[`SBC_INACT_SEL_HI:`SBC_INACT_SEL_LO];
        end
        if (hit(wr_addr_reg, `SBC_ADDR_XCVR)) begin
          mode_reg    <= sbc_lin_mode_e'(wr_data_reg[`SBC_MODE_HI:`SBC_MODE_LO]);
          dto_dis_reg <= wr_data_reg[`SBC_DTO_DIS_BIT];
        end
        if (hit(wr_addr_reg, `SBC_ADDR_SWITCH)) begin
          sw_en_reg    <= wr_data_reg[`SBC_SW_EN_BIT];
          sw_src_reg   <= sbc_sw_src_e'(wr_data_reg[`SBC_SW_SRC_HI:`SBC_SW_SRC_LO]);
          sw_spare_reg <= wr_data_reg[`SBC_SW_SPARE_HI:0];
        end
        if (hit(wr_addr_reg, `SBC_ADDR_PWM_FREQ)) begin
          freq_reg <= wr_data_reg[`SBC_FREQ_BIT];
        end
        if (hit(wr_addr_reg, `SBC_ADDR_DUTY_UPPER)) begin
          duty_up_reg <= wr_data_reg[`SBC_DUTY_UP_HI:0];
        end
        if (hit(wr_addr_reg, `SBC_ADDR_DUTY_LOWER)) begin
          duty_lo_reg <= wr_data_reg;
        end
      end
      if (expire) begin
        mode_reg <= SBC_MODE_SLEEP;
      end
    end
  end

  // first pwm generator
  sbc_pwm_if #(.W(DUTY_W)) pwm_bus ();

  assign pwm_bus.duty      = {duty_up_reg, duty_lo_reg};
  assign pwm_bus.freq_fast = freq_reg;

  sbc_pwm_gen #(.W(DUTY_W)) u_pwm (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pwm     (pwm_bus.gen)
  );

  // switch drive from the selected source; reserved codes keep it off
  logic sw_on_reg;
  logic fso_en_reg;
  logic sleep_req_reg;
  logic pwm_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sw_on_reg  <= 1'b0;
      fso_en_reg <= 1'b1;
      pwm_reg    <= 1'b0;
    end else begin
      pwm_reg    <= pwm_bus.pwm_out;
      fso_en_reg <= (sw_src_reg != SBC_SRC_EXT_PIN);
      unique case (sw_src_reg)
        SBC_SRC_ONOFF:      sw_on_reg <= sw_en_reg;
        SBC_SRC_FIRST_PWM:  sw_on_reg <= sw_en_reg & pwm_bus.pwm_out;
        SBC_SRC_SECOND_PWM: sw_on_reg <= sw_en_reg & second_pwm;
        SBC_SRC_FIRST_TMR:  sw_on_reg <= sw_en_reg & first_on_timer;
        SBC_SRC_SECOND_TMR: sw_on_reg <= sw_en_reg & second_on_timer;
        SBC_SRC_EXT_PIN:    sw_on_reg <= sw_en_reg & ext_ctrl;
        SBC_SRC_RSVD6,
        SBC_SRC_RSVD7:      sw_on_reg <= 1'b0;
      endcase
    end
  end

  // one-cycle sleep request on expiry
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_req_reg <= 1'b0;
    end else begin
      sleep_req_reg <= expire;
    end
  end

  // timer status output
  logic running_reg;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= timer_run;
    end
  end

  // outputs, each straight from a flop
  assign spi_miso_o               = miso_reg;
  assign spi_miso_oe              = miso_oe_reg;
  assign transceiver_mode         = mode_reg;
  assign dominant_timeout_disable = dto_dis_reg;
  assign high_side_switch         = sw_on_reg;
  assign fail_safe_output_enable  = fso_en_reg;
  assign first_pwm                = pwm_reg;
  assign inactivity_timer_running = running_reg;
  assign sleep_request            = sleep_req_reg;

endmodule : sbc_cfg_top

// [rtl/sbc_cfg_params.svh]
`ifndef SBC_CFG_PARAMS_SVH
`define SBC_CFG_PARAMS_SVH

// register offsets (7-bit spi address space)
`define SBC_ADDR_INACT        7'h1c
`define SBC_ADDR_XCVR         7'h1d
`define SBC_ADDR_SWITCH       7'h1e
`define SBC_ADDR_PWM_FREQ     7'h1f
`define SBC_ADDR_DUTY_UPPER   7'h20
`define SBC_ADDR_DUTY_LOWER   7'h21

// field positions
`define SBC_INACT_DIS_BIT     7
`define SBC_INACT_SEL_HI      6
`define SBC_INACT_SEL_LO      3
`define SBC_MODE_HI           7
`define SBC_MODE_LO           6
`define SBC_DTO_DIS_BIT       5
`define SBC_SW_EN_BIT         7
`define SBC_SW_SRC_HI         6
`define SBC_SW_SRC_LO         4
`define SBC_SW_SPARE_HI       3
`define SBC_FREQ_BIT          7
`define SBC_DUTY_UP_HI        1

// reset values
`define SBC_RST_INACT         8'h30
`define SBC_RST_XCVR          8'h00
`define SBC_RST_SWITCH        8'h00
`define SBC_RST_PWM_FREQ      8'h00
`define SBC_RST_DUTY_UPPER    8'h00
`define SBC_RST_DUTY_LOWER    8'h00

// spi frame: write flag, 7 address bits, 8 data bits
`define SBC_FRAME_BITS        16
`define SBC_HDR_BITS          8

// timing
`define SBC_CLK_HZ            100000000
`define SBC_TIMEOUT_STEP_S    30
`define SBC_STEP_CYCLES       (64'd30 * 64'd100000000)
`define SBC_PWM_SLOW_HZ       200
`define SBC_PWM_FAST_HZ       400
`define SBC_PWM_STEPS         1024
`define SBC_PWM_SLOW_STEP     (`SBC_CLK_HZ / (`SBC_PWM_SLOW_HZ * `SBC_PWM_STEPS))
`define SBC_PWM_FAST_STEP     (`SBC_CLK_HZ / (`SBC_PWM_FAST_HZ * `SBC_PWM_STEPS))

`endif

// [rtl/sbc_cfg_pkg.sv]
package sbc_cfg_pkg;

  // transceiver mode field codes
  typedef enum logic [1:0] {
    SBC_MODE_STANDBY = 2'h0,
    SBC_MODE_SLEEP   = 2'h1,
    SBC_MODE_NORMAL  = 2'h2,
    SBC_MODE_FAST    = 2'h3
  } sbc_lin_mode_e;

  // switch control source codes
  typedef enum logic [2:0] {
    SBC_SRC_ONOFF      = 3'h0,
    SBC_SRC_FIRST_PWM  = 3'h1,
    SBC_SRC_SECOND_PWM = 3'h2,
    SBC_SRC_FIRST_TMR  = 3'h3,
    SBC_SRC_SECOND_TMR = 3'h4,
    SBC_SRC_EXT_PIN    = 3'h5,
    SBC_SRC_RSVD6      = 3'h6,
    SBC_SRC_RSVD7      = 3'h7
  } sbc_sw_src_e;

  // spi frame states
  typedef enum logic [3:0] {
    SBC_SPI_IDLE = 4'h1,
    SBC_SPI_HDR  = 4'h2,
    SBC_SPI_DATA = 4'h4,
    SBC_SPI_HOLD = 4'h8
  } sbc_spi_state_e;

  typedef logic [7:0] sbc_byte_t;

endpackage : sbc_cfg_pkg

// [rtl/sbc_pwm_if.sv]
`timescale 1ns/1ps

interface sbc_pwm_if #(
  parameter int W = 10
);
  logic [W-1:0] duty;
  logic         freq_fast;
  logic         pwm_out;

  modport ctrl (output duty, output freq_fast, input pwm_out);
  modport gen  (input duty, input freq_fast, output pwm_out);
endinterface : sbc_pwm_if

// [rtl/sbc_pwm_gen.sv]
`timescale 1ns/1ps
`include "sbc_cfg_params.svh"

module sbc_pwm_gen
  import sbc_cfg_pkg::*;
#(
  parameter int          W         = 10,
  parameter logic [15:0] SLOW_STEP = 16'(`SBC_PWM_SLOW_STEP),
  parameter logic [15:0] FAST_STEP = 16'(`SBC_PWM_FAST_STEP)
)(
  input wire logic clk_sys,
  input wire logic sys_rst,
  sbc_pwm_if.gen   pwm
);

  logic [15:0]  pre_reg;
  logic [W-1:0] cnt_reg;
  logic         out_reg;
  logic [15:0]  step_len;

  // prescale length from the selected frequency
  assign step_len = pwm.freq_fast ? FAST_STEP : SLOW_STEP;

  // free-running prescaler and 10-bit period counter
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pre_reg <= 16'h0;
      cnt_reg <= '0;
    end else if (pre_reg >= step_len - 16'h1) begin
      pre_reg <= 16'h0;
      cnt_reg <= cnt_reg + 1'b1;
    end else begin
      pre_reg <= pre_reg + 16'h1;
    end
  end

  // compare against duty; all ones keeps the output high throughout
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= 1'b0;
    end else if (&pwm.duty) begin
      out_reg <= 1'b1;
    end else begin
      out_reg <= (cnt_reg < pwm.duty);
    end
  end

  assign pwm.pwm_out = out_reg;

endmodule : sbc_pwm_gen

// [tb/sbc_cfg_sva.sv]
`timescale 1ns/1ps

module sbc_cfg_sva (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       spi_cs_n,
  input wire logic [1:0] transceiver_mode,
  input wire logic       dominant_timeout_disable,
  input wire logic       high_side_switch,
  input wire logic       fail_safe_output_enable,
  input wire logic       first_pwm,
  input wire logic       inactivity_timer_running,
  input wire logic       sleep_request
);
  logic [4:0] idle_cnt_reg;

  // cycles since chip select was last active, saturating
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      idle_cnt_reg <= 5'h1f;
    end else if (!spi_cs_n) begin
      idle_cnt_reg <= 5'h00;
    end else if (idle_cnt_reg != 5'h1f) begin
      idle_cnt_reg <= idle_cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // expiry events and the forced sleep mode
  a_expiry_forces_sleep: assert property (sleep_request |-> ##[0:2] (transceiver_mode == 2'h1))
    else $error("expiry did not force sleep mode");
  a_expiry_single_pulse: assert property (sleep_request |=> !sleep_request)
    else $error("expiry pulse longer than one cycle");
  a_expiry_needs_timer: assert property (sleep_request |-> $past(inactivity_timer_running))
    else $error("expiry without a running timer");
  a_sleep_stops_timer: assert property ((transceiver_mode == 2'h1) [*3] |-> !inactivity_timer_running)
    else $error("timer runs in sleep mode");
  // values right after reset release
  a_release_defaults: assert property ($fell(sys_rst) |-> (transceiver_mode == 2'h0) && !high_side_switch
    && fail_safe_output_enable && !dominant_timeout_disable && !sleep_request)
    else $error("wrong output after reset release");
  a_timer_default_on: assert property ($fell(sys_rst) |-> ##[0:1] inactivity_timer_running)
    else $error("timer not enabled by default");
  // register-driven outputs move only after a frame; the mode may also move after an expiry
  a_dto_by_frame: assert property ($changed(dominant_timeout_disable) |-> (idle_cnt_reg < 5'd20))
    else $error("dominant timeout disable changed without a frame");
  a_fso_by_frame: assert property ($changed(fail_safe_output_enable) |-> (idle_cnt_reg < 5'd20))
    else $error("fail-safe enable changed without a frame");
  a_mode_by_cause: assert property ($changed(transceiver_mode) |-> (idle_cnt_reg < 5'd20)
    || sleep_request || $past(sleep_request) || $past(sleep_request, 2))
    else $error("mode changed without a frame or expiry");

  // main scenarios reached
  c_expiry: cover property (sleep_request);
  c_ext_pin: cover property (!fail_safe_output_enable);
  c_pwm_on: cover property (high_side_switch && first_pwm);
endmodule : sbc_cfg_sva

// [tb/sbc_spi_host.sv]
`timescale 1ns/1ps

module sbc_spi_host (
  input  wire logic clk_sys,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic miso_line
);
  // idle bus at time zero
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  // one 16-bit mode-0 frame, msb first; read bits taken just before each of the eight data-byte rises
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_sys);
    spi_cs_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= frame[i];
      repeat (6) @(posedge clk_sys);
      if (i < 8) rd[i] = miso_line;
      spi_sclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~spi_mosi;  // data line does not keep its last value
    repeat (8) @(posedge clk_sys);
  endtask : xfer
endmodule : sbc_spi_host

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "sbc_cfg_params.svh"

module tb_top
  import sbc_cfg_pkg::*;
();
  localparam int STEP_T = 200;
  localparam logic [6:0] ADDR   [7] = '{`SBC_ADDR_INACT, `SBC_ADDR_XCVR, `SBC_ADDR_SWITCH,
    `SBC_ADDR_PWM_FREQ, `SBC_ADDR_DUTY_UPPER, `SBC_ADDR_DUTY_LOWER, 7'h30};
  localparam logic [7:0] RST_V  [7] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] FULL_V [7] = '{8'hf8, 8'he0, 8'hff, 8'h80, 8'h03, 8'hff, 8'h00};

  logic       clk_sys, sys_rst, spi_cs_n, spi_sclk, spi_mosi;
  logic       spi_miso_o, spi_miso_oe, miso_fill, miso_line;
  logic       second_pwm, first_on_timer, second_on_timer, ext_pin;
  logic [1:0] transceiver_mode;
  logic       dominant_timeout_disable, high_side_switch, fail_safe_output_enable;
  logic       first_pwm, inactivity_timer_running, sleep_request, exp_sw;
  int         num_errors, cmp_count, cycle_cnt, sleep_cnt, n;

  sbc_cfg_top #(.STEP_CYCLES(32'(STEP_T))) u_sbc_cfg_top (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .second_pwm(second_pwm), .first_on_timer(first_on_timer),
    .second_on_timer(second_on_timer), .external_switch_pin_control(ext_pin),
    .transceiver_mode(transceiver_mode), .dominant_timeout_disable(dominant_timeout_disable),
    .high_side_switch(high_side_switch), .fail_safe_output_enable(fail_safe_output_enable),
    .first_pwm(first_pwm), .inactivity_timer_running(inactivity_timer_running),
    .sleep_request(sleep_request));

  sbc_spi_host u_sbc_spi_host (.clk_sys(clk_sys), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .miso_line(miso_line));

  // released miso line shows a changing pattern, never the last bit
  assign miso_line = spi_miso_oe ? spi_miso_o : miso_fill;

  always #5 clk_sys = ~clk_sys;

  // cycle count, expiry count and hang limit
  always @(posedge clk_sys) begin
    miso_fill <= ~miso_fill;
    cycle_cnt <= cycle_cnt + 1;
    if (sleep_request === 1'b1) sleep_cnt <= sleep_cnt + 1;
    if (cycle_cnt == 25000) begin
      num_errors++;
      $display("FAIL t=%0t run did not finish", $time);
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    u_sbc_spi_host.xfer({1'b1, a, d}, dummy);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] got;
    u_sbc_spi_host.xfer({1'b0, a, 8'h00}, got);
    chk(got, exp, "readback");
  endtask : rd_chk

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    miso_fill = 1'b0;
    {second_pwm, first_on_timer, second_on_timer, ext_pin} = 4'h0;
    {num_errors, cmp_count, cycle_cnt, sleep_cnt} = '0;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 7; i++) rd_chk(ADDR[i], RST_V[i]);
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) wr(ADDR[i], 8'hff);
    for (int i = 0; i < 7; i++) rd_chk(ADDR[i], FULL_V[i]);
    chk(8'(inactivity_timer_running), 8'h00, "timer off");
    chk(8'(transceiver_mode), 8'(SBC_MODE_FAST), "mode fast");
    chk(8'(dominant_timeout_disable), 8'h01, "dto off");
    chk(8'(first_pwm), 8'h01, "duty full");
    chk(8'(high_side_switch), 8'h00, "reserved source");
    $display("test stored_bits done");
    for (int m = 0; m < 4; m++) begin
      wr(`SBC_ADDR_XCVR, {2'(m), 6'h00});
      chk(8'(transceiver_mode), 8'(m), "mode");
      chk(8'(dominant_timeout_disable), 8'h00, "dto on");
    end
    $display("test modes done");
    for (int ph = 0; ph < 2; ph++) begin
      {second_pwm, first_on_timer, second_on_timer, ext_pin} <= {2{ph[0], !ph[0]}};
      for (int s = 0; s < 6; s++) begin
        wr(`SBC_ADDR_SWITCH, {1'b1, 3'(s), 4'h0});
        repeat (8) @(posedge clk_sys);
        exp_sw = (s < 2) ? 1'b1 : (ph[0] ^ s[0]);
        chk(8'(high_side_switch), 8'(exp_sw), "switch source");
        chk(8'(fail_safe_output_enable), 8'(s != 5), "fail-safe");
      end
    end
    wr(`SBC_ADDR_SWITCH, {1'b0, SBC_SRC_ONOFF, 4'h0});
    chk(8'(high_side_switch), 8'h00, "switch disabled");
    wr(`SBC_ADDR_DUTY_UPPER, 8'h00);
    wr(`SBC_ADDR_DUTY_LOWER, 8'h00);
    wr(`SBC_ADDR_SWITCH, {1'b1, SBC_SRC_FIRST_PWM, 4'h0});
    repeat (4) @(posedge clk_sys);
    chk(8'(first_pwm), 8'h00, "duty zero");
    chk(8'(high_side_switch), 8'h00, "pwm source off");
    $display("test switch done");
    wr(`SBC_ADDR_INACT, {1'b0, 4'hd, 3'h0});
    chk(8'(inactivity_timer_running), 8'h01, "timer on");
    n = 0;
    while (sleep_request !== 1'b1 && n < 2 * STEP_T) begin
      @(posedge clk_sys);
      n++;
    end
    chk(8'(n > STEP_T - 50 && n < STEP_T + 30), 8'h01, "expiry time");
    repeat (4) @(posedge clk_sys);
    chk(8'(transceiver_mode), 8'(SBC_MODE_SLEEP), "forced sleep");
    chk(8'(inactivity_timer_running), 8'h00, "timer stopped");
    wr(`SBC_ADDR_INACT, {1'b0, 4'hf, 3'h0});
    wr(`SBC_ADDR_XCVR, 8'h80);
    n = sleep_cnt;
    repeat (3) rd_chk(`SBC_ADDR_XCVR, 8'h80);
    chk(8'(sleep_cnt - n), 8'h00, "kept awake");
    $display("test inactivity done");
    end_of_test();
  end
endmodule : tb_top

bind sbc_cfg_top sbc_cfg_sva u_sbc_cfg_sva (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
  .transceiver_mode(transceiver_mode), .dominant_timeout_disable(dominant_timeout_disable),
  .high_side_switch(high_side_switch), .fail_safe_output_enable(fail_safe_output_enable),
  .first_pwm(first_pwm), .inactivity_timer_running(inactivity_timer_running),
  .sleep_request(sleep_request));
